/* File: rtl/prldr_pkg.sv */
// Purpose: Shared constants and types for the reconfiguration loader
// Assumes: One core clock, image bytes arrive on the same clock
// Notes: Register offsets are byte addresses on the plain register port
package prldr_pkg;
   // Register offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_REGION_SEL = 4'h4;
   localparam logic [3:0] ADDR_EXPECT_ID = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   // Field positions and reset values
   localparam int CTRL_START_BIT = 0;
   localparam int STAT_CODE_LSB = 0;
   localparam int STAT_IDX_LSB = 2;
   localparam logic [31:0] EXPECT_ID_RST = 32'h0000_0000;
   localparam logic [31:0] REGION_SEL_RST = 32'h0000_0001;
   // Status codes
   localparam logic [1:0] STAT_IDLE = 2'h0;
   localparam logic [1:0] STAT_BUSY = 2'h1;
   localparam logic [1:0] STAT_OK = 2'h2;
   localparam logic [1:0] STAT_ERR = 2'h3;
   // Image layout: zero-based index of the identifier word (the 71st word)
   localparam logic [6:0] ID_WORD_IDX = 7'h46;
   localparam logic [6:0] WORD_IDX_MAX = 7'h7F;
   // Identifier scheme limits
   localparam int MAX_REGIONS = 32;
   localparam int MAX_LAYERS = 6;
   localparam int MAX_CHILDREN = 15;
   localparam int MAX_GLOBALS = 33;
   // Region reset: cycles the region logic needs, plus the extra cycle
   localparam int RST_NEED_DEF = 4;
   localparam int RST_EXTRA = 1;
   // Frozen output value
   localparam logic CLAMP_LEVEL = 1'b0;

   // Assembled configuration word toward the configuration manager
   typedef struct packed {
      logic [31:0] data;
      logic last;
   } prldr_word_s;

   // Loader states
   typedef enum logic [2:0] {ST_IDLE, ST_FREEZE, ST_LOAD, ST_RESET, ST_DONE, ST_ERR} prldr_state_e;
endpackage : prldr_pkg

/* File: rtl/prldr_freeze.sv */
// Purpose: Clamps the outputs of reconfigurable regions while frozen
// Assumes: Region outputs are on sys_clk; one freeze bit per region
// Notes: Inputs into the regions are never gated, only outputs
module prldr_freeze import prldr_pkg::*; #(
   parameter int NUM_REGIONS = 2,
   parameter int OUT_W = 32
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [NUM_REGIONS-1:0] freeze,
   input wire logic [NUM_REGIONS*OUT_W-1:0] region_dout,
   input wire logic [NUM_REGIONS-1:0] region_wr_en,
   output logic [NUM_REGIONS*OUT_W-1:0] static_dout,
   output logic [NUM_REGIONS-1:0] static_wr_en
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // One registered clamp per region; same port set for every persona
   for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_reg
      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            static_dout[i*OUT_W +: OUT_W] <= '0;
            static_wr_en[i] <= 1'b0;
         end else if (freeze[i]) begin // see RULE6 see RULE18
            static_dout[i*OUT_W +: OUT_W] <= {OUT_W{CLAMP_LEVEL}};
            static_wr_en[i] <= CLAMP_LEVEL;
         end else begin // see RULE15
            static_dout[i*OUT_W +: OUT_W] <= region_dout[i*OUT_W +: OUT_W];
            static_wr_en[i] <= region_wr_en[i];
         end
      end

      chk_frozen_clamp: assert property (freeze[i] |=> // see RULE6
         (static_wr_en[i] == CLAMP_LEVEL && static_dout[i*OUT_W +: OUT_W] == {OUT_W{CLAMP_LEVEL}}))
         else $error("frozen region output not clamped");
   end
endmodule : prldr_freeze

/* File: rtl/prldr_loader.sv */
// Purpose: Reconfiguration image loader with compatibility check and freeze
// Assumes: Host and regions share sys_clk; host keeps off the regions while busy
// Notes: Bytes pack little endian into words; status holds until next start
// Summary of operation
// RULE1: Check 71st image word against expected identifier.
// RULE2: Mismatch halts load, refuses bytes, reports error.
// RULE3: Checking is build option; off means plain word.
// RULE4: Four bytes per word, earliest byte lowest.
// RULE5: Host avoids region traffic during reconfiguration.
// RULE6: Freeze clamps every region output and write enable.
// RULE7: No gating on signals entering the region.
// RULE8: Reset reconfigured regions before normal operation resumes.
// RULE9: Reset pulse one cycle longer than needed.
// RULE10: At most thirty-two regions with checking enabled.
// RULE11: At most six nesting layers with checking.
// RULE12: At most fifteen children per parent region.
// RULE13: Authentication requires checking; checking defaults enabled.
// RULE14: Merged image freezes and resets all targets.
// RULE15: Wrapper exposes union of all persona ports.
// RULE16: At most thirty-three global signals per region.
// RULE17: Host finishes pending region transactions before start.
// RULE18: Outputs inactive while region reset and frozen.
// RULE19: Freeze before first word until reset done.
// RULE20: Status shows idle, busy, success, error; error held.
module prldr_loader import prldr_pkg::*; #(
   parameter bit COMPAT_CHECK_EN = 1'b1,
   parameter bit AUTH_EN = 1'b0,
   parameter int NUM_REGIONS = 2,
   parameter int NUM_LAYERS = 1,
   parameter int NUM_CHILDREN = 0,
   parameter int NUM_GLOBALS = 1,
   parameter int RST_NEED = RST_NEED_DEF,
   parameter int OUT_W = 32
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_last,
   output logic byte_ready,
   output prldr_word_s word_out,
   output logic word_valid,
   input wire logic word_ready,
   output logic [1:0] status,
   output logic [NUM_REGIONS-1:0] region_freeze,
   output logic [NUM_REGIONS-1:0] region_rst_n,
   input wire logic [NUM_REGIONS*OUT_W-1:0] region_dout,
   input wire logic [NUM_REGIONS-1:0] region_wr_en,
   output logic [NUM_REGIONS*OUT_W-1:0] static_dout,
   output logic [NUM_REGIONS-1:0] static_wr_en
);
   // Reset pulse length including the margin for duplicated registers
   localparam int RST_LEN = RST_NEED + RST_EXTRA; // see RULE9

   // Elaboration checks on the build options
   if (NUM_REGIONS < 1 || NUM_REGIONS > 32) begin : g_bad_regions
      $error("region count out of range");
   end
   if (COMPAT_CHECK_EN && NUM_REGIONS > MAX_REGIONS) begin : g_bad_total // see RULE10
      $error("too many regions for identifier scheme");
   end
   if (COMPAT_CHECK_EN && (NUM_LAYERS < 1 || NUM_LAYERS > MAX_LAYERS)) begin : g_bad_layers // see RULE11
      $error("too many nesting layers");
   end
   if (NUM_CHILDREN > MAX_CHILDREN || NUM_CHILDREN >= NUM_REGIONS) begin : g_bad_child // see RULE12
      $error("too many child regions");
   end
   if (AUTH_EN && !COMPAT_CHECK_EN) begin : g_bad_auth // see RULE13
      $error("authentication needs compatibility checking");
   end
   if (NUM_GLOBALS < 1 || NUM_GLOBALS > MAX_GLOBALS) begin : g_bad_glob // see RULE16
      $error("too many global signals per region");
   end
   if (RST_NEED < 1 || RST_LEN > 63) begin : g_bad_rst
      $error("reset length out of range");
   end
   if (OUT_W < 1) begin : g_bad_w
      $error("region output width must be positive");
   end

   // Places one byte into a partial word, bytes above it read as zero
   function automatic logic [31:0] pack_word(input logic [23:0] part, input logic [7:0] b,
                                             input logic [1:0] pos);
      logic [31:0] w;
      w = '0;
      for (int k = 0; k < 3; k++) begin
         if (k < int'(pos)) begin
            w[k*8 +: 8] = part[k*8 +: 8];
         end
      end
      w[int'(pos)*8 +: 8] = b; // see RULE4
      return w;
   endfunction : pack_word

   prldr_state_e state_r, state_nxt;
   logic [NUM_REGIONS-1:0] region_sel_r;
   logic [NUM_REGIONS-1:0] act_mask_r;
   logic [31:0] expect_id_r;
   logic [23:0] asm_r;
   logic [1:0] byte_pos_r;
   logic [6:0] word_idx_r;
   logic [5:0] rst_cnt_r;
   logic start_req;
   logic byte_take;
   logic word_done;
   logic [31:0] full_word;
   logic id_slot;
   logic id_bad;
   logic word_take;
   logic frozen;

   // Register port decode
   assign start_req = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_START_BIT];

   // Stream handshakes and word completion
   assign byte_ready = state_r == ST_LOAD && !word_valid; // see RULE2
   assign byte_take = byte_valid && byte_ready;
   assign word_done = byte_take && (byte_pos_r == 2'h3 || byte_last);
   assign full_word = pack_word(asm_r, byte_data, byte_pos_r);
   assign id_slot = COMPAT_CHECK_EN && word_idx_r == ID_WORD_IDX; // see RULE3
   assign id_bad = word_done && id_slot && full_word != expect_id_r; // see RULE1
   assign word_take = word_valid && word_ready;

   // Software-written configuration registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         region_sel_r <= NUM_REGIONS'(REGION_SEL_RST);
         expect_id_r <= EXPECT_ID_RST;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_REGION_SEL) begin
            region_sel_r <= reg_wdata[NUM_REGIONS-1:0];
         end
         if (reg_addr == ADDR_EXPECT_ID) begin
            expect_id_r <= reg_wdata;
         end
      end
   end

   // Read data, valid the cycle after the read strobe; unmapped reads zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_REGION_SEL: reg_rdata <= 32'(region_sel_r);
            ADDR_EXPECT_ID: reg_rdata <= expect_id_r;
            ADDR_STATUS: reg_rdata <= {23'h0, word_idx_r, status};
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Loader sequence; a start while busy is ignored
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE, ST_DONE, ST_ERR: begin
            if (start_req) begin // see RULE17
               state_nxt = ST_FREEZE;
            end
         end
         ST_FREEZE: state_nxt = ST_LOAD; // see RULE19
         ST_LOAD: begin
            if (id_bad) begin // see RULE2
               state_nxt = ST_ERR;
            end else if (word_take && word_out.last) begin // see RULE8
               state_nxt = ST_RESET;
            end
         end
         ST_RESET: begin
            if (rst_cnt_r == 6'(RST_LEN - 1)) begin // see RULE9
               state_nxt = ST_DONE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Regions targeted by this image, caught at start
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         act_mask_r <= '0;
      end else if (state_nxt == ST_FREEZE) begin // see RULE14
         act_mask_r <= region_sel_r;
      end
   end

   // Byte assembly into little-endian words
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         asm_r <= '0;
         byte_pos_r <= '0;
      end else if (state_r == ST_FREEZE) begin
         asm_r <= '0;
         byte_pos_r <= '0;
      end else if (byte_take) begin // see RULE4
         asm_r <= full_word[23:0];
         byte_pos_r <= word_done ? 2'h0 : byte_pos_r + 2'h1;
      end
   end

   // Word index within the image, saturating
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         word_idx_r <= '0;
      end else if (state_r == ST_FREEZE) begin
         word_idx_r <= '0;
      end else if (word_done && word_idx_r != WORD_IDX_MAX) begin
         word_idx_r <= word_idx_r + 7'h1;
      end
   end

   // Outgoing word holding register; a bad identifier is never forwarded
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         word_valid <= 1'b0;
         word_out <= '0;
      end else if (word_done && !id_bad) begin // see RULE3
         word_valid <= 1'b1;
         word_out.data <= full_word;
         word_out.last <= byte_last;
      end else if (word_take) begin
         word_valid <= 1'b0;
      end
   end

   // Region reset length counter
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_cnt_r <= '0;
      end else if (state_r == ST_RESET) begin
         rst_cnt_r <= rst_cnt_r + 6'h1;
      end else begin
         rst_cnt_r <= '0;
      end
   end

   // Freeze and reset toward the targeted regions
   assign frozen = state_r inside {ST_FREEZE, ST_LOAD, ST_RESET, ST_ERR};
   assign region_freeze = frozen ? act_mask_r : '0; // see RULE19 see RULE14
   assign region_rst_n = (state_r == ST_RESET) ? ~act_mask_r : '1; // see RULE8

   // Status code decode, error held until the next start
   always_comb begin
      case (state_r)
         ST_IDLE: status = STAT_IDLE;
         ST_DONE: status = STAT_OK;
         ST_ERR: status = STAT_ERR; // see RULE20
         default: status = STAT_BUSY;
      endcase
   end

   // Output clamps; region inputs pass ungated
   prldr_freeze #(
      .NUM_REGIONS(NUM_REGIONS),
      .OUT_W(OUT_W)
   ) u_freeze (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .freeze(region_freeze), // see RULE7
      .region_dout(region_dout),
      .region_wr_en(region_wr_en),
      .static_dout(static_dout),
      .static_wr_en(static_wr_en)
   );

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   logic rst_any;
   logic [5:0] hlp_rst_cnt;
   assign rst_any = |(~region_rst_n);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hlp_rst_cnt <= '0;
      end else begin
         hlp_rst_cnt <= rst_any ? hlp_rst_cnt + 6'h1 : 6'h0;
      end
   end

   sequence s_last_out;
      word_valid && word_ready && word_out.last && state_r == ST_LOAD;
   endsequence

   sequence s_region_reset;
      (region_rst_n == ~act_mask_r) && (region_freeze == act_mask_r);
   endsequence

   chk_freeze_first: assert property (byte_take |-> (region_freeze == act_mask_r && act_mask_r != '0)) // see RULE19
      else $error("byte accepted without freeze");
   chk_id_mismatch: assert property (id_bad |=> status == STAT_ERR && !word_valid) // see RULE1
      else $error("identifier mismatch not reported");
   chk_err_refuse: assert property (status == STAT_ERR |-> !byte_ready) // see RULE2
      else $error("bytes accepted after abort");
   chk_byte_order: assert property (byte_take && byte_pos_r == 2'h3 && !id_bad
      |=> word_out.data[31:24] == $past(byte_data) && word_out.data[23:16] == $past(asm_r[23:16])) // see RULE4
      else $error("byte lane order wrong");
   chk_rst_length: assert property ($fell(rst_any) |-> hlp_rst_cnt == 6'(RST_LEN)) // see RULE9
      else $error("region reset length wrong");
   chk_reset_after: assert property (s_last_out |=> s_region_reset) // see RULE8
      else $error("no region reset after last word");
   chk_err_hold: assert property (status == STAT_ERR && !start_req |=> status == STAT_ERR) // see RULE20
      else $error("error status not held");
   chk_no_check_off: assert property (!COMPAT_CHECK_EN |-> status != STAT_ERR) // see RULE3
      else $error("error without compatibility checking");
   chk_freeze_held: assert property (state_r == ST_RESET |-> region_freeze == act_mask_r) // see RULE18
      else $error("freeze dropped during region reset");

   // A start that the sequencer actually takes, from any resting state
   sequence s_start_taken;
      start_req && state_r inside {ST_IDLE, ST_DONE, ST_ERR};
   endsequence

   // Start, stream hold, identifier forwarding and release behaviour
   chk_start_freeze: assert property (s_start_taken |=> region_freeze == $past(region_sel_r)) // see RULE19
      else $error("start did not freeze targeted regions");
   chk_busy_start: assert property (start_req && state_r == ST_LOAD |=> state_r != ST_FREEZE) // see RULE19
      else $error("start taken while busy");
   chk_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_out)) // see RULE4
      else $error("pending word changed before taken");
   chk_id_forward: assert property (word_done && id_slot && !id_bad |=> word_out.data == $past(expect_id_r)) // see RULE1
      else $error("matching identifier not forwarded");
   chk_freeze_release: assert property (state_r == ST_DONE |-> region_freeze == '0 && region_rst_n == '1) // see RULE19
      else $error("freeze or reset held after success");
   chk_idle_quiet: assert property (status == STAT_IDLE |-> region_freeze == '0 && !byte_ready) // see RULE20
      else $error("idle loader freezing or taking bytes");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0) // see RULE20
      else $error("read data left standing");
endmodule : prldr_loader

/* File: bench/prldr_host_model.sv */
// Purpose: Host model streaming a numbered reconfiguration image
// Assumes: Same clock as the loader; a byte moves on valid and ready
// Notes: Idle data line shows the inverse of the last byte sent
module prldr_host_model (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic go,
   input wire logic [9:0] nbytes,
   input wire logic byte_ready,
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic byte_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] idx_r;
   logic [7:0] last_r;
   // Byte k of the image: first word 02 1B EE 01, then the low count bits
   function automatic logic [7:0] img_byte(input logic [9:0] k);
      logic [31:0] w0;
      w0 = 32'h01EE_1B02;
      return (k < 10'h004) ? w0[k[1:0]*8 +: 8] : k[7:0];
   endfunction : img_byte
   // Holds each byte until taken; the model never touches region traffic
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         idx_r <= 10'h000;
         byte_valid <= 1'b0;
         last_r <= 8'h00;
      end else if (go) begin
         idx_r <= 10'h000;
         byte_valid <= 1'b1;
      end else if (byte_valid && byte_ready) begin
         last_r <= img_byte(idx_r);
         idx_r <= idx_r + 10'h001;
         byte_valid <= (idx_r + 10'h001 < nbytes);
      end
   end
   // Released line carries the inverse of the last byte
   assign byte_data = byte_valid ? img_byte(idx_r) : ~last_r;
   assign byte_last = byte_valid && (idx_r == nbytes - 10'h001);
endmodule : prldr_host_model

/* File: bench/prldr_loader_bench.sv */
// Purpose: Self-checking bench for the reconfiguration loader
// Assumes: Default parameters; a second loader built with checking off
// Notes: Only one loader is started at a time, both share the host model
module prldr_loader_bench import prldr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RST_LEN = RST_NEED_DEF + RST_EXTRA;
   logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, use2 = 1'b0, go = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
   logic [9:0] nbytes = 10'h120;
   logic byte_valid, byte_last, ready_a, ready_b, wv_a, wv_b, word_ready = 1'b0;
   logic [7:0] byte_data;
   prldr_word_s word_a, word_b;
   prldr_word_s got[$];
   logic [1:0] status_a, status_b, frz, rgn_rst_n, static_wr_en;
   logic [1:0] region_wr_en = 2'h3;
   logic [63:0] region_dout = 64'hA5A5_0F0F_5A5A_F0F0, static_dout;
   int errors = 0, checks = 0, cyc = 0;
   always #2 sys_clk = ~sys_clk;
   prldr_host_model host_u (.sys_clk(sys_clk), .arst_n(arst_n), .go(go), .nbytes(nbytes),
      .byte_ready(ready_a | ready_b), .byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last));
   prldr_loader dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr & ~use2), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_last(byte_last), .byte_ready(ready_a), .word_out(word_a), .word_valid(wv_a),
      .word_ready(word_ready), .status(status_a), .region_freeze(frz), .region_rst_n(rgn_rst_n),
      .region_dout(region_dout), .region_wr_en(region_wr_en), .static_dout(static_dout),
      .static_wr_en(static_wr_en));
   prldr_loader #(.COMPAT_CHECK_EN(1'b0)) dut2_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr & use2), .reg_rd(1'b0), .reg_rdata(), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_last(byte_last), .byte_ready(ready_b), .word_out(word_b), .word_valid(wv_b),
      .word_ready(word_ready), .status(status_b), .region_freeze(), .region_rst_n(), .region_dout(region_dout),
      .region_wr_en(region_wr_en), .static_dout(), .static_wr_en());
   // Sink stalls one cycle in four and collects every word taken
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      word_ready <= (cyc % 4) != 3;
      if (wv_a === 1'b1 && word_ready) got.push_back(word_a);
      if (wv_b === 1'b1 && word_ready) got.push_back(word_b);
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end
   task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] seen);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp
   task automatic end_sim();
      if (errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d, input logic with_go);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      go <= with_go;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      go <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_read
   function automatic logic [31:0] exp_word(input int i);
      logic [7:0] b;
      b = 8'(4 * i);
      return (i == 0) ? 32'h01EE_1B02 : {b + 8'h03, b + 8'h02, b + 8'h01, b};
   endfunction : exp_word
   task automatic wait_words(input int n);
      for (int k = 0; k < 4000 && got.size() < n; k++) @(negedge sys_clk); // Sink push already done
      #1;
   endtask : wait_words
   task automatic start_load(input logic [1:0] mask, input logic [31:0] id);
      got.delete();
      reg_write(ADDR_REGION_SEL, {30'h0, mask}, 1'b0);
      reg_write(ADDR_EXPECT_ID, id, 1'b0);
      reg_write(ADDR_CTRL, 32'h1, 1'b1);
   endtask : start_load
   task automatic test_reset_values();
      logic [3:0] addrs [5] = '{ADDR_CTRL, ADDR_REGION_SEL, ADDR_EXPECT_ID, ADDR_STATUS, 4'h2};
      logic [31:0] exps [5] = '{32'h0, REGION_SEL_RST, EXPECT_ID_RST, 32'h0, 32'h0};
      for (int i = 0; i < 5; i++) begin
         reg_read(addrs[i], rd_val);
         cmp("reset register", exps[i], rd_val);
      end
      cmp("idle status", STAT_IDLE, status_a);
   endtask : test_reset_values
   task automatic test_good_load();
      int cnt;
      start_load(2'h3, 32'h1B1A_1918);
      #1 cmp("freeze at start", 2'h3, frz);
      cmp("busy status", STAT_BUSY, status_a);
      @(posedge sys_clk);
      #1 cmp("frozen data", 64'h0, static_dout);
      cmp("frozen write enable", 2'h0, static_wr_en);
      wait_words(10);
      reg_write(ADDR_CTRL, 32'h1, 1'b0);
      wait_words(72);
      cmp("word count", 72, got.size());
      for (int i = 0; i < got.size(); i++) cmp("word data", exp_word(i), got[i].data);
      cmp("last flag", 1'b1, got[71].last);
      for (int k = 0; k < 20 && rgn_rst_n !== 2'h0; k++) @(posedge sys_clk) #1;
      cmp("freeze in reset", 2'h3, frz);
      cnt = 0;
      while (rgn_rst_n === 2'h0 && cnt < 50) begin
         cnt++;
         @(posedge sys_clk) #1;
      end
      cmp("reset length", RST_LEN, cnt);
      repeat (3) @(posedge sys_clk);
      #1 cmp("success status", STAT_OK, status_a);
      cmp("freeze released", 2'h0, frz);
      cmp("live data", region_dout, static_dout);
      cmp("live write enable", region_wr_en, static_wr_en);
      reg_read(ADDR_STATUS, rd_val);
      cmp("status register", STAT_OK, rd_val[1:0]);
   endtask : test_good_load
   task automatic test_mismatch();
      start_load(2'h1, 32'h1234_5678);
      wait_words(70);
      repeat (20) @(posedge sys_clk);
      #1 cmp("words before halt", 70, got.size());
      cmp("error status", STAT_ERR, status_a);
      cmp("bytes refused", 2'h2, {byte_valid, ready_a});
      cmp("freeze held", 2'h1, frz);
      cmp("no region reset", 2'h3, rgn_rst_n);
      cmp("clamped region", 32'h0, static_dout[31:0]);
      cmp("free region", region_dout[63:32], static_dout[63:32]);
      reg_read(ADDR_STATUS, rd_val);
      cmp("error status register", {23'h0, ID_WORD_IDX + 7'h1, STAT_ERR}, rd_val);
      repeat (50) @(posedge sys_clk);
      #1 cmp("error held", STAT_ERR, status_a);
   endtask : test_mismatch
   task automatic test_check_off();
      @(posedge sys_clk);
      use2 <= 1'b1;
      nbytes <= 10'h11E;
      start_load(2'h1, 32'h1234_5678);
      wait_words(72);
      cmp("unchecked count", 72, got.size());
      for (int i = 0; i < 71; i++) cmp("unchecked data", exp_word(i), got[i].data);
      cmp("partial word", 32'h0000_1D1C, got[71].data);
      cmp("partial last flag", 1'b1, got[71].last);
      for (int k = 0; k < 40 && status_b !== STAT_OK; k++) @(posedge sys_clk) #1;
      cmp("unchecked status", STAT_OK, status_b);
   endtask : test_check_off
   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      test_reset_values();
      test_good_load();
      test_mismatch();
      test_check_off();
      end_sim();
   end
endmodule : prldr_loader_bench
